// File: counter_array_defines.svh
// Register offsets, field positions, reset values and timing counts for the counter array.
`ifndef COUNTER_ARRAY_DEFINES_SVH
`define COUNTER_ARRAY_DEFINES_SVH
`define CTRL_ADDR 8'hd8
`define MODE_ADDR 8'hd9
`define CTRL_OVF_BIT 7
`define CTRL_RUN_BIT 6
`define MODE_IDLE_BIT 7
`define MODE_WDE_BIT 6
`define MODE_LOCK_BIT 5
`define MODE_TB_LSB 1
`define MODE_OIE_BIT 0
`define CTRL_RESET 8'h00
`define MODE_RESET 8'h40
`define DIV12_COUNT 4'hb
`define DIV4_COUNT 4'h3
`define EXT_DIV_COUNT 3'h7
`endif

// File: counter_array_pkg.sv
// Types shared by the counter array control logic.
package counter_array_pkg;
    typedef enum logic [2:0] {
        TB_DIV12 = 3'h0,
        TB_DIV4 = 3'h1,
        TB_T0OVF = 3'h2,
        TB_EXTIN = 3'h3,
        TB_SYSCLK = 3'h4,
        TB_EXTDIV8 = 3'h5
    } timebase_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;
endpackage

// File: counter_array_control_mode.sv
// Control and mode registers, timebase selection and counter for the counter array.
`timescale 1ns/1ps
`include "counter_array_defines.svh"

// Functional notes
// - Overflow flag sets when the counter wraps from 0xFFFF to 0x0000.
// - Overflow flag requests the shared interrupt only while its enable is 1.
// - All four flags stay set until software writes zero to them.
// - Run bit stops the counter at 0 unless watchdog is enabled, and lets it tick at 1.
// - Control bits 5 to 3 read zero and ignore writes.
// - Module event strobes set control bits 2, 1 and 0.
// - A module flag with its enable set requests the shared interrupt.
// - Idle suspend bit halts dividers, event flags and counting while the CPU idles.
// - Watchdog enable hands module 2 over as watchdog; zero disables it.
// - After lock is written, clearing watchdog enable is ignored until reset.
// - Mode bit 4 reads zero and ignores writes.
// - Timebase codes pick clock/12, clock/4, timer 0 overflow or clock.
// - Code 011 counts falling external edges; source at most clock/4.
// - Code 101 ticks every eight external clocks, resynchronised.
// - While watchdog enabled, other mode bits ignore writes.
// - Mode register resets with only watchdog enable set.
// - Watchdog enabled forces the counter to run.
// - Writing one to module 2 flag with watchdog on forces reset.
module counter_array_control_mode (
    input wire logic clock,
    input wire logic rst,
    input wire counter_array_pkg::sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic cpu_idle,
    input wire logic timer0_overflow,
    input wire logic external_count_input,
    input wire logic ext_osc_clk,
    input wire logic [2:0] module_event,
    input wire logic [2:0] module_irq_enable,
    output logic irq,
    output logic [15:0] count,
    output logic overflow_strobe,
    output logic tick,
    output logic watchdog_enable,
    output logic watchdog_force_reset
);
    logic [7:0] ctrl_q;
    logic [7:0] mode_q;
    logic [15:0] count_q;
    logic [3:0] div12_q;
    logic [1:0] div4_q;
    logic [2:0] eci_q;
    logic [2:0] xosc_q;
    logic [2:0] xdiv_q;
    logic tick_q;
    logic ovf_q;
    logic irq_q;
    logic wdr_q;
    logic [7:0] rdata_q;
    logic ctrl_wr;
    logic mode_wr;
    logic wde;
    logic active;
    logic run;
    logic tick_d;
    logic wrap;
    logic [2:0] tb_sel;

    assign ctrl_wr = sfr_req.wr && sfr_req.addr == `CTRL_ADDR;
    assign mode_wr = sfr_req.wr && sfr_req.addr == `MODE_ADDR;
    assign wde = mode_q[`MODE_WDE_BIT];
    assign tb_sel = mode_q[`MODE_TB_LSB +: 3];
    // Idle suspension freezes dividers and counting, but not input sampling.
    assign active = !(cpu_idle && mode_q[`MODE_IDLE_BIT]);
    assign run = ctrl_q[`CTRL_RUN_BIT] || wde;
    assign wrap = run && tick_d && count_q == 16'hffff;

    // Prescalers run whenever not suspended, so the select can change freely.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            div12_q <= 4'h0;
            div4_q <= 2'h0;
        end else if (active) begin
            div12_q <= (div12_q == `DIV12_COUNT) ? 4'h0 : div12_q + 4'h1;
            div4_q <= div4_q + 2'h1;
        end
    end

    // External edges: eci_q[0] is the first sampling stage, the rest detect the edge.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            eci_q <= 3'h7;
        end else begin
            eci_q <= {eci_q[1:0], external_count_input};
        end
    end

    // The external oscillator is oversampled; it must be well below the system clock.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            xosc_q <= 3'h0;
            xdiv_q <= 3'h0;
        end else begin
            xosc_q <= {xosc_q[1:0], ext_osc_clk};
            if (active && xosc_q[1] && !xosc_q[2]) begin
                xdiv_q <= xdiv_q + 3'h1;
            end
        end
    end

    always_comb begin
        case (tb_sel)
            counter_array_pkg::TB_DIV12: tick_d = div12_q == `DIV12_COUNT;
            counter_array_pkg::TB_DIV4: tick_d = div4_q == `DIV4_COUNT;
            counter_array_pkg::TB_T0OVF: tick_d = timer0_overflow;
            counter_array_pkg::TB_EXTIN: tick_d = eci_q[2] && !eci_q[1];
            counter_array_pkg::TB_SYSCLK: tick_d = 1'b1;
            counter_array_pkg::TB_EXTDIV8: tick_d = xosc_q[1] && !xosc_q[2]
                && xdiv_q == `EXT_DIV_COUNT;
            default: tick_d = 1'b0;
        endcase
        tick_d = tick_d && active;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_q <= 16'h0000;
            ovf_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= run && tick_d;
            ovf_q <= wrap;
            if (run && tick_d) begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    // Hardware set beats a software clear in the same cycle.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_q <= `CTRL_RESET;
        end else begin
            if (ctrl_wr) begin
                ctrl_q <= sfr_req.wdata & 8'hc7;
            end
            if (wrap) begin
                ctrl_q[`CTRL_OVF_BIT] <= 1'b1;
            end
            for (int i = 0; i < 3; i++) begin
                if (module_event[i] && active) begin
                    ctrl_q[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_q <= `MODE_RESET;
        end else if (mode_wr) begin
            if (!wde) begin
                mode_q <= sfr_req.wdata & 8'hef;
                // Setting the lock enables the watchdog in the same edge, so a write
                // that follows at once cannot clear the lock before it takes hold.
                mode_q[`MODE_WDE_BIT] <= sfr_req.wdata[`MODE_WDE_BIT]
                    | sfr_req.wdata[`MODE_LOCK_BIT];
            end else begin
                // Only the enable and lock bits stay writable while guarding.
                mode_q[`MODE_LOCK_BIT] <= mode_q[`MODE_LOCK_BIT]
                    | sfr_req.wdata[`MODE_LOCK_BIT];
                mode_q[`MODE_WDE_BIT] <= sfr_req.wdata[`MODE_WDE_BIT]
                    | mode_q[`MODE_LOCK_BIT] | sfr_req.wdata[`MODE_LOCK_BIT];
            end
        end else if (mode_q[`MODE_LOCK_BIT]) begin
            mode_q[`MODE_WDE_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
            wdr_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            irq_q <= (ctrl_q[`CTRL_OVF_BIT] && mode_q[`MODE_OIE_BIT])
                || |(ctrl_q[2:0] & module_irq_enable);
            wdr_q <= ctrl_wr && wde && sfr_req.wdata[2];
            if (sfr_req.addr == `CTRL_ADDR) begin
                rdata_q <= ctrl_q & 8'hc7;
            end else if (sfr_req.addr == `MODE_ADDR) begin
                rdata_q <= mode_q & 8'hef;
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    assign sfr_rdata = rdata_q;
    assign irq = irq_q;
    assign count = count_q;
    assign overflow_strobe = ovf_q;
    assign tick = tick_q;
    assign watchdog_enable = wde;
    assign watchdog_force_reset = wdr_q;

    a_ovf_sets: assert property (@(posedge clock) disable iff (rst)
        wrap |=> ctrl_q[7] && overflow_strobe)
        else $error("overflow flag not set on wrap");
    a_flag_sticky: assert property (@(posedge clock) disable iff (rst)
        ctrl_q[7] && !ctrl_wr |=> ctrl_q[7])
        else $error("overflow flag cleared without write");
    a_irq_mask: assert property (@(posedge clock) disable iff (rst)
        ctrl_q[7] && mode_q[0] |=> irq)
        else $error("overflow irq missing");
    a_mod_flag: assert property (@(posedge clock) disable iff (rst)
        module_event[1] && active |=> ctrl_q[1])
        else $error("module flag not set");
    a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
        ctrl_q[5:3] == 3'h0 && mode_q[4] == 1'b0)
        else $error("reserved bits nonzero");
    a_lock_holds: assert property (@(posedge clock) disable iff (rst)
        mode_q[5] |=> mode_q[6] && mode_q[5])
        else $error("locked watchdog was disabled");
    a_mode_frozen: assert property (@(posedge clock) disable iff (rst)
        wde |=> mode_q[4:0] == $past(mode_q[4:0]) && mode_q[7] == $past(mode_q[7]))
        else $error("mode bits changed while guarding");
    a_run_stop: assert property (@(posedge clock) disable iff (rst)
        !run |=> count_q == $past(count_q))
        else $error("counter moved while stopped");
    a_idle_hold: assert property (@(posedge clock) disable iff (rst)
        !active |=> !tick)
        else $error("tick during idle suspend");
    a_wd_force: assert property (@(posedge clock) disable iff (rst)
        ctrl_wr && wde && sfr_req.wdata[2] |=> watchdog_force_reset)
        else $error("forced watchdog reset missing");
    a_wd_quiet: assert property (@(posedge clock) disable iff (rst)
        !(ctrl_wr && wde && sfr_req.wdata[2]) |=> !watchdog_force_reset)
        else $error("watchdog reset without request");

    // A wrap gives exactly one strobe, since the next wrap is a full count away.
    sequence s_wrap_pulse;
        overflow_strobe ##1 !overflow_strobe;
    endsequence
    a_ovf_pulse: assert property (@(posedge clock) disable iff (rst)
        wrap |=> s_wrap_pulse)
        else $error("overflow strobe not a single pulse");
    a_ovf_only: assert property (@(posedge clock) disable iff (rst)
        !wrap |=> !overflow_strobe)
        else $error("overflow strobe without wrap");

    // A clearing write with no competing event leaves the flag low.
    sequence s_clear_mod0;
        ctrl_wr && !sfr_req.wdata[0] && !module_event[0];
    endsequence
    a_mod0_clear: assert property (@(posedge clock) disable iff (rst)
        s_clear_mod0 |=> !ctrl_q[0])
        else $error("module 0 flag not cleared by write");
    a_mod0_sticky: assert property (@(posedge clock) disable iff (rst)
        ctrl_q[0] && !ctrl_wr |=> ctrl_q[0])
        else $error("module 0 flag cleared without write");
    a_mod1_sticky: assert property (@(posedge clock) disable iff (rst)
        ctrl_q[1] && !ctrl_wr |=> ctrl_q[1])
        else $error("module 1 flag cleared without write");
    a_mod2_sticky: assert property (@(posedge clock) disable iff (rst)
        ctrl_q[2] && !ctrl_wr |=> ctrl_q[2])
        else $error("module 2 flag cleared without write");
    a_mod0_flag: assert property (@(posedge clock) disable iff (rst)
        module_event[0] && active |=> ctrl_q[0])
        else $error("module 0 flag not set");
    a_mod2_flag: assert property (@(posedge clock) disable iff (rst)
        module_event[2] && active |=> ctrl_q[2])
        else $error("module 2 flag not set");

    a_irq_module: assert property (@(posedge clock) disable iff (rst)
        |(ctrl_q[2:0] & module_irq_enable) |=> irq)
        else $error("module irq missing");
    a_irq_quiet: assert property (@(posedge clock) disable iff (rst)
        !(ctrl_q[7] && mode_q[0]) && !(|(ctrl_q[2:0] & module_irq_enable)) |=> !irq)
        else $error("irq without enabled flag");

    a_count_step: assert property (@(posedge clock) disable iff (rst)
        run && tick_d |=> count_q == $past(count_q) + 16'h0001)
        else $error("counter did not advance on tick");
    a_tick_stopped: assert property (@(posedge clock) disable iff (rst)
        !run |=> !tick)
        else $error("tick while stopped");
    a_wd_counts: assert property (@(posedge clock) disable iff (rst)
        wde && tick_d |=> tick)
        else $error("watchdog did not force the counter on");
    a_idle_count: assert property (@(posedge clock) disable iff (rst)
        !active |=> count_q == $past(count_q))
        else $error("counter moved during idle suspend");

    a_sysclk_tick: assert property (@(posedge clock) disable iff (rst)
        active && run && tb_sel == 3'h4 |=> tick)
        else $error("system clock tick missing");
    a_div12_gap: assert property (@(posedge clock) disable iff (rst)
        tb_sel == 3'h0 && div12_q != `DIV12_COUNT |-> !tick_d)
        else $error("divide by 12 ticked early");
    a_ext_fall: assert property (@(posedge clock) disable iff (rst)
        active && run && tb_sel == 3'h3 && $fell(eci_q[1]) |=> tick)
        else $error("external falling edge not counted");
    a_ext_rise: assert property (@(posedge clock) disable iff (rst)
        tb_sel == 3'h3 && !$fell(eci_q[1]) |-> !tick_d)
        else $error("tick without external falling edge");
    a_extdiv_rate: assert property (@(posedge clock) disable iff (rst)
        tb_sel == 3'h5 && tick_d |-> xdiv_q == `EXT_DIV_COUNT)
        else $error("external divide tick off count");
    a_reserved_tb: assert property (@(posedge clock) disable iff (rst)
        tb_sel[2:1] == 2'b11 |-> !tick_d)
        else $error("tick from reserved timebase code");

    a_ctrl_readback: assert property (@(posedge clock) disable iff (rst)
        $past(sfr_req.addr) == `CTRL_ADDR |-> sfr_rdata == $past(ctrl_q))
        else $error("control readback wrong");
    a_mode_readback: assert property (@(posedge clock) disable iff (rst)
        $past(sfr_req.addr) == `MODE_ADDR |-> sfr_rdata == $past(mode_q))
        else $error("mode readback wrong");
    a_lock_sets: assert property (@(posedge clock) disable iff (rst)
        mode_wr && sfr_req.wdata[5] |=> mode_q[6] && mode_q[5])
        else $error("lock write did not enable watchdog");
endmodule

// File: cpu_model.sv
// CPU core model that reaches the counter array through its register bus.
`timescale 1ns/1ps
module cpu_model (
    input wire logic clock,
    output counter_array_pkg::sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata
);
    initial sfr_req = '0;
    // Code 111 is used only in the ignored mode frozen write; mode frozen and wd off write with the watchdog on, the locked check sets its lock with it off.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        #1 sfr_req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        #1 sfr_req.addr = a;
        @(posedge clock);
        #1 d = sfr_rdata;
    endtask
endmodule

// File: counter_array_control_mode_test.sv
// Self-checking testbench for the counter array control and mode logic.
`timescale 1ns/1ps
`include "counter_array_defines.svh"
module counter_array_control_mode_test;
    logic clock = 0, rst = 1, cpu_idle = 0, t0 = 0, ext = 1;
    logic [2:0] mev = '0, mie = '0;
    counter_array_pkg::sfr_req_t req;
    logic [7:0] rdata, v;
    logic irq, ovf, tick, wde, wfr, seen;
    logic [15:0] count, c0;
    int failures = 0, checks_done = 0, cyc = 0, n;
    int exp_t[6] = '{80, 240, 192, 120, 960, 15};
    always #20 clock = ~clock;
    // External inputs toggle every four cycles, inside the allowed clock/4 rate.
    always @(posedge clock) #1 begin
        cyc++;
        t0 = (cyc % 5 == 0);
        ext = cyc[2];
        if (cyc == 90000) begin
            failures++;
            complete_run();
        end
    end
    cpu_model cpu (.clock(clock), .sfr_req(req), .sfr_rdata(rdata));
    counter_array_control_mode uut (.clock(clock), .rst(rst), .sfr_req(req), .sfr_rdata(rdata),
        .cpu_idle(cpu_idle), .timer0_overflow(t0), .external_count_input(ext),
        .ext_osc_clk(ext), .module_event(mev), .module_irq_enable(mie), .irq(irq),
        .count(count), .overflow_strobe(ovf), .tick(tick), .watchdog_enable(wde),
        .watchdog_force_reset(wfr));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        #1 rst = 0;
        cpu.rd(`CTRL_ADDR, v);
        check("ctrl reset", v, 8'h00);
        cpu.rd(`MODE_ADDR, v);
        check("mode reset", v, 8'h40);
        check("wd enable", wde, 1'b1);
        c0 = count;
        repeat (120) @(posedge clock);
        check("forced run", count != c0, 1'b1);
        cpu.wr(`MODE_ADDR, 8'h4f);
        cpu.rd(`MODE_ADDR, v);
        check("mode frozen", v, 8'h40);
        cpu.wr(`MODE_ADDR, 8'h00);
        cpu.rd(`MODE_ADDR, v);
        check("wd off", {v, 7'h00, wde}, 16'h0000);
        c0 = count;
        repeat (30) @(posedge clock);
        check("stopped", count, c0);
        cpu.wr(`MODE_ADDR, 8'h99);
        cpu.rd(`MODE_ADDR, v);
        check("mode bit4", v, 8'h89);
        cpu.wr(`CTRL_ADDR, 8'h78);
        cpu.rd(`CTRL_ADDR, v);
        check("ctrl 5:3", v, 8'h40);
        $display("test registers done");
        for (int k = 0; k < 6; k++) begin
            cpu.wr(`MODE_ADDR, 8'h80 | 8'(k << 1));
            n = 0;
            repeat (960) begin
                @(posedge clock);
                #1 n += int'(tick);
            end
            check("ticks", n >= exp_t[k] - 1 && n <= exp_t[k] + 1, 1'b1);
        end
        cpu_idle = 1;
        c0 = count;
        repeat (50) @(posedge clock);
        check("idle hold", count, c0);
        cpu_idle = 0;
        $display("test timebase done");
        cpu.wr(`MODE_ADDR, 8'h09);
        n = 0;
        while (count !== 16'hffff && n < 70000) begin
            @(posedge clock);
            #1 n++;
        end
        @(posedge clock);
        #1 check("ovf strobe", ovf, 1'b1);
        repeat (2) @(posedge clock);
        #1 check("ovf irq", irq, 1'b1);
        cpu.wr(`CTRL_ADDR, 8'h80);
        cpu.rd(`CTRL_ADDR, v);
        check("ovf flag", v, 8'h80);
        cpu.wr(`MODE_ADDR, 8'h08);
        cpu.rd(`MODE_ADDR, v);
        check("irq masked", irq, 1'b0);
        cpu.wr(`CTRL_ADDR, 8'h00);
        mie = 3'b010;
        for (int i = 0; i < 3; i++) begin
            mev[i] = 1'b1;
            @(posedge clock);
            #1 mev = '0;
            cpu.rd(`CTRL_ADDR, v);
            check("event flag", v, 8'(1 << i));
            check("event irq", irq, i == 1);
            cpu.wr(`CTRL_ADDR, 8'h00);
        end
        $display("test flags done");
        cpu.wr(`MODE_ADDR, 8'h20);
        cpu.wr(`MODE_ADDR, 8'h00);
        cpu.rd(`MODE_ADDR, v);
        check("locked", {v, 7'h00, wde}, 16'h6001);
        cpu.wr(`CTRL_ADDR, 8'h04);
        seen = wfr;
        repeat (2) begin
            @(posedge clock);
            #1 seen |= wfr;
        end
        check("wd reset", seen, 1'b1);
        $display("test watchdog done");
        complete_run();
    end
endmodule
